// ===== fsp_codec_model.sv
`timescale 1ns/1ps
`default_nettype none
module fsp_codec_model
(
  output logic      tx_clk_out,   // tx serial clock
  output logic      tx_frame_out, // resolved frame pin
  input  wire logic tx_dout_in,   // port data
  input  wire logic tx_oe_in,     // port data enable
  input  wire logic fs_out_in,    // port frame
  input  wire logic fs_oe_in,     // port frame enable
  output logic      rx_clk_out,   // rx serial clock
  output logic      rx_frame_out, // rx frame
  output logic      rx_data_out   // rx data
);
  logic        frm;
  logic [31:0] cap;
  int          capn;
  int          fcnt;
  // clocks stand still until a burst is asked for
  initial
  begin
    tx_clk_out = 1'b0;
    rx_clk_out = 1'b0;
    rx_frame_out = 1'b0;
    rx_data_out = 1'b0;
    frm = 1'b0;
    cap = '0;
  end
  // frame pin is ours only while the port does not drive it
  assign tx_frame_out = fs_oe_in ? fs_out_in : frm;
  // n tx periods, frames from us at periods fa and fb, capture on falling
  task automatic tx_run(input int n, input int fa, input int fb);
    capn = 0;
    fcnt = 0;
    for (int i = 0; i < n; i++)
    begin
      #6 tx_clk_out = 1'b1;
      #1 frm = (i == fa) || (i == fb);
      #5 tx_clk_out = 1'b0;
      if (tx_oe_in === 1'b1)
      begin
        cap = {cap[30:0], tx_dout_in};
        capn++;
      end
      if (fs_oe_in === 1'b1 && fs_out_in === 1'b1)
        fcnt++;
    end
  endtask
  // idle edges, a frame, then n bits msb first; data toggles when unused
  task automatic rx_word(input logic [15:0] w, input int n);
    for (int i = -3; i <= n + 1; i++)
    begin
      #6 rx_clk_out = 1'b1;
      #1 rx_frame_out = (i == 0 && n > 0);
      rx_data_out = (i >= 1 && i <= n) ? w[n - i] : ~rx_data_out;
      #5 rx_clk_out = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// ===== fsp_defines.svh
`ifndef FSP_DEFINES_SVH
`define FSP_DEFINES_SVH

// data-memory addresses of the two holding registers
`define FSP_ADDR_TX_HOLD   16'h0000
`define FSP_ADDR_RX_HOLD   16'h0001

// bits per transfer for each word format
`define FSP_BITS_WORD      5'h10
`define FSP_BITS_BYTE      5'h08

// field positions inside the status-word-two load value
`define FSP_ST2_FO_POS     0
`define FSP_ST2_TXM_POS    1
`define FSP_ST2_FSM_POS    2

// reset values
`define FSP_RST_FO         1'h0
`define FSP_RST_TXM        1'h0
`define FSP_RST_FSM        1'h1
`define FSP_RST_HOLD       16'h0000

`endif

// ===== fsp_pkg.sv
`default_nettype none
package fsp_pkg;

  // one data-memory access from the core
  typedef struct packed {
    logic        rd;        // read strobe
    logic        wr;        // write strobe
    logic        blk_move;  // read belongs to the data-to-data block move
    logic [15:0] addr;      // data address
    logic [15:0] wdata;     // write data
  } fsp_bus_req_t;

  // serial port control bits of status word two
  typedef struct packed {
    logic fsm;  // sync_required_bit
    logic tx_sync_source_bit;  // tx_sync_source_bit
    logic fo;   // word_format_bit
  } fsp_cfg_t;

endpackage
`default_nettype wire

// ===== fsp_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module fsp_tb_top;
  import fsp_pkg::*;
  logic         ref_clk_in = 1'b0;
  logic         rst_n_in = 1'b0;
  fsp_bus_req_t req = '0;
  logic [5:0]   ins = '0;
  logic [15:0]  sval = '0;
  logic [15:0]  rdata;
  logic         rvalid, txd, txoe, fso, fsoe, txc, tx_frame_pulse, rxc, rx_frame_pulse, rxd, txi, rxi;
  fsp_cfg_t     st2;
  int           fails = 0;
  int           compares = 0;
  int           cyc = 0;
  int           ntx = 0;
  int           nrx = 0;

  always #5 ref_clk_in = ~ref_clk_in;

  fsp_top dut (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .ce_in(1'b1),
    .bus_req_in(req), .bus_rdata_out(rdata), .bus_rvalid_out(rvalid),
    .load_format_instr_in(ins[0]), .format_value_in(sval[0]),
    .load_status_two_instr_in(ins[1]), .status_two_value_in(sval),
    .set_tx_sync_source_instr_in(ins[2]), .clear_tx_sync_source_instr_in(ins[3]),
    .set_sync_required_instr_in(ins[4]), .clear_sync_required_instr_in(ins[5]),
    .status_two_out(st2), .tx_serial_clock_in(txc), .tx_serial_out_out(txd),
    .tx_serial_oe_out(txoe), .tx_frame_pulse_in(tx_frame_pulse), .tx_frame_pulse_out(fso),
    .tx_frame_pulse_oe_out(fsoe), .rx_serial_clock_in(rxc), .rx_serial_in_in(rxd),
    .rx_frame_pulse_in(rx_frame_pulse), .tx_done_irq_out(txi), .rx_done_irq_out(rxi));

  fsp_codec_model codec (.tx_clk_out(txc), .tx_frame_out(tx_frame_pulse), .tx_dout_in(txd),
    .tx_oe_in(txoe), .fs_out_in(fso), .fs_oe_in(fsoe), .rx_clk_out(rxc),
    .rx_frame_out(rx_frame_pulse), .rx_data_out(rxd));

  task automatic conclude;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1)
    begin
      fails++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask

  // one data-memory access, held for the taking edge
  task automatic bus(input logic w, input logic b, input logic [15:0] a, input logic [15:0] d);
    @(posedge ref_clk_in);
    req <= '{rd: !w, wr: w, blk_move: b, addr: a, wdata: d};
    @(posedge ref_clk_in);
    req <= '0;
    #1;
  endtask

  // one-cycle instruction pulse
  task automatic op(input logic [5:0] k, input logic [15:0] v);
    @(posedge ref_clk_in);
    ins <= k;
    sval <= v;
    @(posedge ref_clk_in);
    ins <= '0;
    #1;
  endtask

  task automatic t_instr;
    logic [5:0] k [6] = '{6'h04, 6'h20, 6'h01, 6'h08, 6'h10, 6'h02};
    logic [2:0] e [6] = '{3'b110, 3'b010, 3'b011, 3'b001, 3'b101, 3'b001};
    chk(st2 === 3'b100 && txoe === 1'b0 && fsoe === 1'b0, "reset state");
    for (int i = 0; i < 6; i++)
    begin
      op(k[i], 16'h0001);
      chk(st2 === e[i], "status bits");
    end
  endtask

  task automatic t_regs;
    bus(1'b1, 1'b0, 16'h0000, 16'h1234);
    bus(1'b1, 1'b0, 16'h0001, 16'habcd);
    bus(1'b1, 1'b0, 16'h0007, 16'hffff);
    bus(1'b0, 1'b0, 16'h0000, '0);
    chk(rvalid === 1'b1 && rdata === 16'h1234, "tx holding");
    bus(1'b0, 1'b0, 16'h0001, '0);
    chk(rvalid === 1'b1 && rdata === 16'habcd, "rx holding");
    bus(1'b0, 1'b1, 16'h0000, '0);
    chk(rvalid === 1'b0, "block move read");
    bus(1'b0, 1'b0, 16'h0002, '0);
    chk(rvalid === 1'b1 && rdata === 16'h0000, "unmapped read");
  endtask

  // external frame, then a second frame mid-word
  task automatic t_tx_ext;
    op(6'h02, 16'h0004);
    codec.tx_run(4, -1, -1);
    bus(1'b1, 1'b0, 16'h0000, 16'h9c3a);
    codec.tx_run(36, 6, 12);
    chk(codec.cap[15:0] === 16'h9c3a, "external frame word");
    chk(codec.capn > 16 && codec.fcnt == 0, "abort and restart");
  endtask

  // generated frame, byte format
  task automatic t_tx_int;
    op(6'h02, 16'h0007);
    codec.tx_run(4, -1, -1);
    ntx = 0;
    bus(1'b1, 1'b0, 16'h0000, 16'ha5c3);
    codec.tx_run(20, -1, -1);
    repeat (6) @(posedge ref_clk_in);
    chk(codec.cap[7:0] === 8'hc3 && codec.capn == 8, "byte out");
    chk(codec.fcnt == 1 && ntx == 1, "frame and done");
  endtask

  // generated frame once, then bytes repeat with no further frames
  task automatic t_tx_cont;
    op(6'h02, 16'h0003);
    codec.tx_run(4, -1, -1);
    bus(1'b1, 1'b0, 16'h0000, 16'h00a5);
    codec.tx_run(36, -1, -1);
    chk(codec.capn == 32 && codec.cap === 32'ha5a5a5a5, "continuous bytes");
    chk(codec.fcnt == 1, "single frame in continuous run");
  endtask

  task automatic t_rx;
    op(6'h02, 16'h0004);
    codec.rx_word(16'h5ac3, 16);
    repeat (6) @(posedge ref_clk_in);
    bus(1'b0, 1'b0, 16'h0001, '0);
    chk(rdata === 16'h5ac3, "word received");
    op(6'h02, 16'h0005);
    codec.rx_word(16'h007e, 8);
    repeat (6) @(posedge ref_clk_in);
    bus(1'b0, 1'b0, 16'h0001, '0);
    chk(rdata === 16'hc37e && nrx == 2, "byte received");
  endtask

  // done pulses and the hang guard
  always @(posedge ref_clk_in)
  begin
    cyc++;
    if (txi === 1'b1)
      ntx++;
    if (rxi === 1'b1)
      nrx++;
    if (cyc == 5000)
    begin
      fails++;
      conclude();
    end
  end

  initial
  begin
    fork
      codec.tx_run(3, -1, -1);
      codec.rx_word('0, 0);
    join
    repeat (10) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    @(posedge ref_clk_in);
    #1;
    t_instr();
    t_regs();
    t_tx_ext();
    t_tx_int();
    t_tx_cont();
    t_rx();
    conclude();
  end
endmodule
`default_nettype wire

// ===== fsp_top.sv
// Contract
// - transmit and receive both double-buffered: holding plus shift register
// - no lower limit on either serial clock; a stopped clock is fine
// - transmit holding at data address 0, receive holding at address 1
// - all data reads and writes reach them; block-move reads do not
// - shift registers have no address
// - idle holding registers keep written values as general storage
// - format, sync-source and sync-required bits live in status word two
// - format bit 0 moves 16-bit words, 1 moves 8-bit bytes
// - byte format sends the low eight holding bits; a received byte enters low, old low byte moves high
// - format bit loaded by format instruction, cleared on reset
// - sync source 1: frame pin output, pulse on rising edge per write; with sync required 0 only the write that starts the run
// - sync source 0: frame pin input, wait for external frame pulse
// - reset clears sync source bit, frame pin becomes input
// - sync source bit loaded by status load, set and clear instructions
// - sync required 1: frame per transfer; 0: continuous once started
// - sync required bit has its own set and clear instructions
// - with sync required, transmit frame loads shifter and starts shifting
// - frame before last bit aborts word, reloads and restarts at once
// - msb first; transmit on rising, receive on falling serial clock
// - holding loads shifter at start; full receive word moves to holding
// - transfer-complete requests raised after the last bit
// - transmit data pin released while idle and on reset
`timescale 1ns/1ps
`default_nettype none
`include "fsp_defines.svh"

module fsp_top
(
  input  wire logic                ref_clk_in,                  // core clock, 100 MHz
  input  wire logic                rst_n_in,                    // async reset, active low
  input  wire logic                ce_in,                       // core-domain clock enable
  input  wire fsp_pkg::fsp_bus_req_t bus_req_in,                // data-memory access
  output logic [15:0]              bus_rdata_out,               // read data
  output logic                     bus_rvalid_out,              // read data valid pulse
  input  wire logic                load_format_instr_in,        // load format bit
  input  wire logic                format_value_in,             // value for format bit
  input  wire logic                load_status_two_instr_in,    // load status word two
  input  wire logic [15:0]         status_two_value_in,         // value for status load
  input  wire logic                set_tx_sync_source_instr_in, // sync source to 1
  input  wire logic                clear_tx_sync_source_instr_in, // sync source to 0
  input  wire logic                set_sync_required_instr_in,  // sync required to 1
  input  wire logic                clear_sync_required_instr_in, // sync required to 0
  output fsp_pkg::fsp_cfg_t        status_two_out,              // control bits now held
  input  wire logic                tx_serial_clock_in,          // transmit serial clock
  output logic                     tx_serial_out_out,           // transmit data
  output logic                     tx_serial_oe_out,            // transmit data drive enable
  input  wire logic                tx_frame_pulse_in,           // frame pin, input side
  output logic                     tx_frame_pulse_out,          // frame pin, output side
  output logic                     tx_frame_pulse_oe_out,       // frame pin drive enable
  input  wire logic                rx_serial_clock_in,          // receive serial clock
  input  wire logic                rx_serial_in_in,             // receive data
  input  wire logic                rx_frame_pulse_in,           // receive frame pin
  output logic                     tx_done_irq_out,             // transmit complete pulse
  output logic                     rx_done_irq_out              // receive complete pulse
);
  import fsp_pkg::*;

  // ---------------- core domain ----------------
  fsp_cfg_t    cfg_q;
  logic [15:0] tx_hold_q;
  logic [15:0] rx_hold_q;
  logic        tx_load_tgl_q;
  logic [15:0] bus_rdata_q;
  logic        bus_rvalid_q;
  logic [2:0]  tx_done_sync_q;
  logic [2:0]  rx_done_sync_q;
  logic        tx_done_irq_q;
  logic        rx_done_irq_q;
  logic        rx_arrive;
  logic        tx_hit_wr;
  logic        rx_hit_wr;

  // ---------------- transmit domain ----------------
  fsp_cfg_t    cfg_tx_s1_q;
  fsp_cfg_t    cfg_tx_s2_q;
  logic [1:0]  tx_load_sync_q;
  logic        tx_load_seen_q;
  logic        tx_pending_q;
  logic [15:0] tx_snap_q;
  logic [15:0] tx_shifter_q;
  logic [4:0]  tx_bits_q;
  logic        tx_active_q;
  logic        tx_cont_q;
  logic        tx_dout_q;
  logic        tx_oe_q;
  logic        tx_fs_out_q;
  logic        tx_fs_oe_q;
  logic        tx_done_tgl_q;
  logic        tx_new_load;
  logic        tx_gen_frame;
  logic        tx_ext_frame;
  logic        tx_last;
  logic        tx_restart;
  logic        tx_start;
  logic [15:0] tx_load_val;
  logic [4:0]  tx_nbits;

  // ---------------- receive domain ----------------
  fsp_cfg_t    cfg_rx_s1_q;
  fsp_cfg_t    cfg_rx_s2_q;
  logic [15:0] rx_shifter_q;
  logic [15:0] rx_word_q;
  logic [4:0]  rx_bits_q;
  logic        rx_active_q;
  logic        rx_cont_q;
  logic        rx_done_tgl_q;
  logic [4:0]  rx_nbits;

  // address decode; block-move reads are kept out
  assign tx_hit_wr = bus_req_in.wr && (bus_req_in.addr == `FSP_ADDR_TX_HOLD);
  assign rx_hit_wr = bus_req_in.wr && (bus_req_in.addr == `FSP_ADDR_RX_HOLD);
  assign rx_arrive = rx_done_sync_q[2] ^ rx_done_sync_q[1];

  // control bits of status word two
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cfg_q.fo  <= `FSP_RST_FO;
      cfg_q.tx_sync_source_bit <= `FSP_RST_TXM;
      cfg_q.fsm <= `FSP_RST_FSM;
    end
    else if (ce_in)
    begin
      if (load_status_two_instr_in)
      begin
        cfg_q.fo  <= status_two_value_in[`FSP_ST2_FO_POS];
        cfg_q.tx_sync_source_bit <= status_two_value_in[`FSP_ST2_TXM_POS];
        cfg_q.fsm <= status_two_value_in[`FSP_ST2_FSM_POS];
      end
      if (load_format_instr_in)
        cfg_q.fo <= format_value_in;
      if (set_tx_sync_source_instr_in)
        cfg_q.tx_sync_source_bit <= 1'h1;
      else if (clear_tx_sync_source_instr_in)
        cfg_q.tx_sync_source_bit <= 1'h0;
      if (set_sync_required_instr_in)
        cfg_q.fsm <= 1'h1;
      else if (clear_sync_required_instr_in)
        cfg_q.fsm <= 1'h0;
    end
  end

  // transmit holding register plus its load request toggle
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      tx_hold_q     <= `FSP_RST_HOLD;
      tx_load_tgl_q <= 1'h0;
    end
    else if (ce_in && tx_hit_wr)
    begin
      tx_hold_q     <= bus_req_in.wdata;
      tx_load_tgl_q <= ~tx_load_tgl_q;
    end
  end

  // receive holding: an arriving word wins over a same-cycle core write
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      rx_hold_q <= `FSP_RST_HOLD;
    else if (ce_in)
    begin
      if (rx_arrive)
      begin
        if (cfg_q.fo)
          rx_hold_q <= {rx_hold_q[7:0], rx_word_q[7:0]};
        else
          rx_hold_q <= rx_word_q;
      end
      else if (rx_hit_wr)
        rx_hold_q <= bus_req_in.wdata;
    end
  end

  // registered read port, one cycle after the strobe
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      bus_rdata_q  <= 16'h0000;
      bus_rvalid_q <= 1'h0;
    end
    else if (ce_in)
    begin
      bus_rvalid_q <= 1'h0;
      bus_rdata_q  <= 16'h0000;
      if (bus_req_in.rd && !bus_req_in.blk_move)
      begin
        bus_rvalid_q <= 1'h1;
        if (bus_req_in.addr == `FSP_ADDR_TX_HOLD)
          bus_rdata_q <= tx_hold_q;
        else if (bus_req_in.addr == `FSP_ADDR_RX_HOLD)
          bus_rdata_q <= rx_hold_q;
      end
    end
  end

  // done toggles from the serial domains become core pulses
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      tx_done_sync_q <= 3'h0;
      rx_done_sync_q <= 3'h0;
      tx_done_irq_q  <= 1'h0;
      rx_done_irq_q  <= 1'h0;
    end
    else if (ce_in)
    begin
      tx_done_sync_q <= {tx_done_sync_q[1:0], tx_done_tgl_q};
      rx_done_sync_q <= {rx_done_sync_q[1:0], rx_done_tgl_q};
      tx_done_irq_q  <= tx_done_sync_q[2] ^ tx_done_sync_q[1];
      rx_done_irq_q  <= rx_arrive;
    end
  end

  // ================= transmit clock domain =================
  // all serial logic is edge driven only: a stopped clock just pauses it
  assign tx_nbits     = cfg_tx_s2_q.fo ? `FSP_BITS_BYTE : `FSP_BITS_WORD;
  assign tx_load_val  = cfg_tx_s2_q.fo ? {tx_snap_q[7:0], 8'h00} : tx_snap_q;
  assign tx_new_load  = tx_load_sync_q[1] ^ tx_load_seen_q;
  assign tx_last      = tx_active_q && (tx_bits_q == 5'h01);
  assign tx_restart   = tx_last && tx_cont_q && !cfg_tx_s2_q.fsm;
  // internal frame only when a write is pending and no continuous run owns it
  assign tx_gen_frame = cfg_tx_s2_q.tx_sync_source_bit && tx_pending_q &&
                        !(tx_cont_q && tx_active_q && !cfg_tx_s2_q.fsm);
  assign tx_ext_frame = !cfg_tx_s2_q.tx_sync_source_bit && tx_frame_pulse_in;
  assign tx_start     = tx_gen_frame || tx_ext_frame;

  // level synchronisers into the transmit domain
  always_ff @(posedge tx_serial_clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cfg_tx_s1_q    <= '0;
      cfg_tx_s2_q    <= '0;
      tx_load_sync_q <= 2'h0;
      tx_load_seen_q <= 1'h0;
    end
    else
    begin
      cfg_tx_s1_q    <= cfg_q;
      cfg_tx_s2_q    <= cfg_tx_s1_q;
      tx_load_sync_q <= {tx_load_sync_q[0], tx_load_tgl_q};
      tx_load_seen_q <= tx_load_sync_q[1];
    end
  end

  // snapshot of the holding word; pending request survives a same-edge consume
  always_ff @(posedge tx_serial_clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      tx_snap_q    <= `FSP_RST_HOLD;
      tx_pending_q <= 1'h0;
    end
    else
    begin
      if (tx_new_load)
        tx_snap_q <= tx_hold_q; // stable: written two edges earlier
      if (tx_new_load)
        tx_pending_q <= 1'h1;
      else if (tx_start || tx_restart)
        tx_pending_q <= 1'h0;
    end
  end

  // frame pin direction and generated pulse
  always_ff @(posedge tx_serial_clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      tx_fs_out_q <= 1'h0;
      tx_fs_oe_q  <= 1'h0;
    end
    else
    begin
      tx_fs_out_q <= tx_gen_frame;
      tx_fs_oe_q  <= cfg_tx_s2_q.tx_sync_source_bit;
    end
  end

  // transmit shifter: load on frame, one bit per rising edge, msb first
  always_ff @(posedge tx_serial_clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      tx_shifter_q  <= 16'h0000;
      tx_bits_q     <= 5'h00;
      tx_active_q   <= 1'h0;
      tx_cont_q     <= 1'h0;
      tx_dout_q     <= 1'h0;
      tx_oe_q       <= 1'h0;
      tx_done_tgl_q <= 1'h0;
    end
    else if (tx_start)
    begin
      tx_shifter_q <= tx_load_val;
      tx_bits_q    <= tx_nbits;
      tx_active_q  <= 1'h1;
      tx_cont_q    <= !cfg_tx_s2_q.fsm;
    end
    else if (tx_active_q)
    begin
      tx_dout_q    <= tx_shifter_q[15];
      tx_oe_q      <= 1'h1;
      tx_shifter_q <= {tx_shifter_q[14:0], 1'h0};
      tx_bits_q    <= tx_bits_q - 5'h01;
      if (tx_last)
      begin
        tx_done_tgl_q <= ~tx_done_tgl_q;
        if (tx_restart)
        begin
          tx_shifter_q <= tx_load_val;
          tx_bits_q    <= tx_nbits;
        end
        else
          tx_active_q <= 1'h0;
      end
    end
    else
      tx_oe_q <= 1'h0;
  end

  // ================= receive clock domain =================
  assign rx_nbits = cfg_rx_s2_q.fo ? `FSP_BITS_BYTE : `FSP_BITS_WORD;

  // level synchronisers into the receive domain
  always_ff @(negedge rx_serial_clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cfg_rx_s1_q <= '0;
      cfg_rx_s2_q <= '0;
    end
    else
    begin
      cfg_rx_s1_q <= cfg_q;
      cfg_rx_s2_q <= cfg_rx_s1_q;
    end
  end

  // receive shifter: sample on falling edges, whole word handed over by toggle
  always_ff @(negedge rx_serial_clock_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rx_shifter_q  <= 16'h0000;
      rx_word_q     <= 16'h0000;
      rx_bits_q     <= 5'h00;
      rx_active_q   <= 1'h0;
      rx_cont_q     <= 1'h0;
      rx_done_tgl_q <= 1'h0;
    end
    else if (rx_frame_pulse_in)
    begin
      rx_bits_q   <= rx_nbits;
      rx_active_q <= 1'h1;
      rx_cont_q   <= !cfg_rx_s2_q.fsm;
    end
    else if (rx_active_q)
    begin
      rx_shifter_q <= {rx_shifter_q[14:0], rx_serial_in_in};
      rx_bits_q    <= rx_bits_q - 5'h01;
      if (rx_bits_q == 5'h01)
      begin
        rx_word_q     <= {rx_shifter_q[14:0], rx_serial_in_in};
        rx_done_tgl_q <= ~rx_done_tgl_q;
        if (rx_cont_q && !cfg_rx_s2_q.fsm)
          rx_bits_q <= rx_nbits;
        else
          rx_active_q <= 1'h0;
      end
    end
  end

  // outputs straight from flip-flops
  assign bus_rdata_out         = bus_rdata_q;
  assign bus_rvalid_out        = bus_rvalid_q;
  assign status_two_out        = cfg_q;
  assign tx_serial_out_out     = tx_dout_q;
  assign tx_serial_oe_out      = tx_oe_q;
  assign tx_frame_pulse_out    = tx_fs_out_q;
  assign tx_frame_pulse_oe_out = tx_fs_oe_q;
  assign tx_done_irq_out       = tx_done_irq_q;
  assign rx_done_irq_out       = rx_done_irq_q;

endmodule
`default_nettype wire

// ===== fsp_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module fsp_top_asserts
(
  input wire logic                  ref_clk_in,                    // core clk
  input wire logic                  rst_n_in,                      // reset
  input wire logic                  ce_in,                         // enable
  input wire fsp_pkg::fsp_bus_req_t bus_req_in,                    // access
  input wire logic [15:0]           bus_rdata_out,                 // rd data
  input wire logic                  bus_rvalid_out,                // rd valid
  input wire logic                  load_format_instr_in,          // fo load
  input wire logic                  format_value_in,               // fo value
  input wire logic                  load_status_two_instr_in,      // st load
  input wire logic                  set_tx_sync_source_instr_in,   // txm set
  input wire logic                  clear_tx_sync_source_instr_in, // txm clr
  input wire logic                  set_sync_required_instr_in,    // fsm set
  input wire logic                  clear_sync_required_instr_in,  // fsm clr
  input wire fsp_pkg::fsp_cfg_t     status_two_out,                // bits
  input wire logic                  tx_serial_clock_in,            // tx clk
  input wire logic                  tx_serial_oe_out,              // data oe
  input wire logic                  tx_frame_pulse_out,            // frame
  input wire logic                  tx_frame_pulse_oe_out,         // frame oe
  input wire logic                  rx_done_irq_out                // rx done
);
  // core domain: bus answers and control bits
  a_read_answer: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    ce_in && bus_req_in.rd && !bus_req_in.blk_move |=> bus_rvalid_out)
    else $error("read not answered");
  a_blk_refused: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    ce_in && bus_req_in.rd && bus_req_in.blk_move |=> !bus_rvalid_out)
    else $error("block move read answered");
  a_unmapped_zero: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    ce_in && bus_req_in.rd && bus_req_in.addr > 16'h0001 |=> bus_rdata_out == 16'h0000)
    else $error("unmapped read not zero");
  a_txm_set: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    ce_in && set_tx_sync_source_instr_in |=> status_two_out.tx_sync_source_bit)
    else $error("sync source not set");
  a_fsm_clear: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    ce_in && clear_sync_required_instr_in && !set_sync_required_instr_in
    |=> !status_two_out.fsm) else $error("sync required not cleared");
  a_format_load: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    ce_in && load_format_instr_in |=> status_two_out.fo == $past(format_value_in))
    else $error("format not loaded");
  a_status_hold: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    !(ce_in && (load_format_instr_in || load_status_two_instr_in
    || set_tx_sync_source_instr_in || clear_tx_sync_source_instr_in
    || set_sync_required_instr_in || clear_sync_required_instr_in))
    |=> $stable(status_two_out)) else $error("status bits moved");
  // transmit domain: generated frame shape
  a_frame_output: assert property (@(posedge tx_serial_clock_in) disable iff (!rst_n_in)
    tx_frame_pulse_out |-> tx_frame_pulse_oe_out) else $error("frame while input");
  a_frame_single: assert property (@(posedge tx_serial_clock_in) disable iff (!rst_n_in)
    $rose(tx_frame_pulse_out) |=> !tx_frame_pulse_out) else $error("frame too long");
  a_frame_starts: assert property (@(posedge tx_serial_clock_in) disable iff (!rst_n_in)
    $rose(tx_frame_pulse_out) |=> tx_serial_oe_out) else $error("no shift after frame");
  c_read: cover property (@(posedge ref_clk_in) bus_rvalid_out);
  c_frame: cover property (@(posedge tx_serial_clock_in) tx_frame_pulse_out);
  c_rx_done: cover property (@(posedge ref_clk_in) rx_done_irq_out);
endmodule
bind fsp_top fsp_top_asserts u_asserts (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
  .ce_in(ce_in), .bus_req_in(bus_req_in), .bus_rdata_out(bus_rdata_out),
  .bus_rvalid_out(bus_rvalid_out), .load_format_instr_in(load_format_instr_in),
  .format_value_in(format_value_in), .load_status_two_instr_in(load_status_two_instr_in),
  .set_tx_sync_source_instr_in(set_tx_sync_source_instr_in),
  .clear_tx_sync_source_instr_in(clear_tx_sync_source_instr_in),
  .set_sync_required_instr_in(set_sync_required_instr_in),
  .clear_sync_required_instr_in(clear_sync_required_instr_in),
  .status_two_out(status_two_out), .tx_serial_clock_in(tx_serial_clock_in),
  .tx_serial_oe_out(tx_serial_oe_out), .tx_frame_pulse_out(tx_frame_pulse_out),
  .tx_frame_pulse_oe_out(tx_frame_pulse_oe_out), .rx_done_irq_out(rx_done_irq_out));
`default_nettype wire
